// ---- src/scp_pkg.sv ----
// package: constants of the six-channel pwm block
package scp_pkg;

  // channel count and field widths
  localparam int NUM_CH     = 6;
  localparam int CNT_W      = 16;
  localparam int PSC_W      = 3;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;

  // clock rates; the master tick is made from clk by a rate accumulator
  localparam int CLK_MHZ    = 100;
  localparam int MASTER_MHZ = 16;
  localparam logic [7:0] ACC_MOD = 8'(CLK_MHZ);
  localparam logic [7:0] ACC_INC = 8'(MASTER_MHZ);

  // register byte offsets
  localparam logic [ADDR_W-1:0] GLB_OFS    = 8'h00;
  localparam logic [ADDR_W-1:0] CH_BASE    = 8'h04;
  localparam logic [ADDR_W-1:0] CH_STRIDE  = 8'h08;
  localparam logic [ADDR_W-1:0] CH_CFG_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STAT_OFS   = 8'h44;

  // global control word fields
  localparam int GLB_EN0_BIT = 0;
  localparam int GLB_EN4_BIT = 4;
  localparam logic [DATA_W-1:0] GLB_MASK = 32'h0000_0011;

  // channel limit word: period limit low half, threshold high half
  localparam int LIM_TOP_LSB = 0;
  localparam int LIM_THR_LSB = 16;

  // channel config word fields
  localparam int CFG_PSC_LSB = 0;
  localparam int CFG_POL_BIT = 4;
  localparam int CFG_MODE_BIT = 8;
  localparam int CFG_EN_BIT  = 12;
  localparam int CFG_LD_BIT  = 16;
  localparam int CFG_CNT_LSB = 16;

  // status word fields
  localparam int STAT_OUT_LSB = 0;
  localparam int STAT_DIR_LSB = 8;

  // reset values and the prescale code limit
  localparam logic [CNT_W-1:0] TOP_RST = 16'h0000;
  localparam logic [CNT_W-1:0] THR_RST = 16'h0000;
  localparam logic [PSC_W-1:0] PSC_RST = 3'h0;
  localparam logic [PSC_W-1:0] PSC_MAX = 3'h6;

  // counting mode
  typedef enum logic {SCP_MODE_UP, SCP_MODE_UPDOWN} scp_mode_e;

endpackage

// ---- src/scp_pwm.sv ----
// six-channel pwm generator with an apb register slave
// Summary of operation
// - six channels, each independently programmed
// - timing derives from 16 MHz master tick
// - power-of-two prescale, ratio 2 to 128
// - up mode counts zero to limit, wraps
// - output changes level at threshold
// - polarity selects level below threshold
// - up/down mode counts back toward zero
// - per-channel limit, threshold, prescale, flags
// - channel registers follow global control word
module scp_pwm
  import scp_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic [scp_pkg::ADDR_W-1:0] paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [scp_pkg::DATA_W-1:0] pwdata,
  output logic      [scp_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic      [scp_pkg::NUM_CH-1:0] pwm_out
);
  import scp_pkg::*;

  // bus phase decode
  logic                 setup_ph;
  logic                 wr_acc;
  logic                 glb_hit;
  logic                 stat_hit;
  logic                 ch_hit;
  logic                 glb_ok;
  logic [DATA_W-1:0]    glb_r;
  logic [DATA_W-1:0]    rd_mux;
  logic [DATA_W-1:0]    prdata_r;
  logic                 pslverr_r;
  logic [7:0]           acc_r;
  logic [7:0]           acc_sum;
  logic                 mtick;
  logic [NUM_CH-1:0]    lim_hit;
  logic [NUM_CH-1:0]    cfg_hit;
  logic [NUM_CH-1:0]    out_r;
  logic [NUM_CH-1:0]    dir_r;
  logic [DATA_W-1:0]    lim_rd [NUM_CH];
  logic [DATA_W-1:0]    cfg_rd [NUM_CH];
  logic [DATA_W-1:0]    stat_word;

  // zero-wait slave: every access phase completes at once
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign pready   = 1'b1;
  assign prdata   = prdata_r;
  assign pslverr  = pslverr_r;
  assign pwm_out  = out_r;
  assign glb_hit  = (paddr == GLB_OFS);
  assign stat_hit = (paddr == STAT_OFS);
  assign ch_hit   = |{lim_hit, cfg_hit};
  assign glb_ok   = glb_r[GLB_EN0_BIT] & glb_r[GLB_EN4_BIT];

  // status word: pin levels low, count directions from bit 8
  assign stat_word = {18'h0_0000, dir_r, 2'b00, out_r};

  // read data selection, unmapped reads as zero
  // later matches win, but no two decodes ever overlap
  always_comb
  begin
    rd_mux = '0;
    if (glb_hit)
      rd_mux = glb_r;
    else if (stat_hit)
      rd_mux = stat_word;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (lim_hit[i])
        rd_mux = lim_rd[i];
      if (cfg_hit[i])
        rd_mux = cfg_rd[i];
    end
  end

  // answer captured in setup so read data leaves a flop
  // both answers are ready by the access phase, so pready stays high
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_r  <= rd_mux;
      pslverr_r <= ~(glb_hit | stat_hit | ch_hit);
    end
  end

  // global control word; only bits 0 and 4 exist
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      glb_r <= '0;
    else if (wr_acc && glb_hit)
      glb_r <= pwdata & GLB_MASK;
  end

  // average 16 MHz tick from the 100 MHz clock
  // ticks jitter by one clock; the long-run rate is exact
  assign acc_sum = acc_r + ACC_INC;
  assign mtick   = (acc_sum >= ACC_MOD);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      acc_r <= '0;
    else
      acc_r <= mtick ? acc_sum - ACC_MOD : acc_sum;
  end

  // one independent channel per loop pass
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    logic [CNT_W-1:0] top_sh_r;
    logic [CNT_W-1:0] thr_sh_r;
    logic [PSC_W-1:0] psc_sh_r;
    logic [CNT_W-1:0] top_r;
    logic [CNT_W-1:0] thr_r;
    logic [PSC_W-1:0] psc_r;
    logic             pol_r;
    scp_mode_e        mode_r;
    logic             en_r;
    logic             ld_r;
    logic [6:0]       psc_cnt_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             dir_nxt;
    logic [PSC_W-1:0] psc_eff;
    logic [6:0]       psc_lim;
    logic             step;
    logic             bnd;
    logic             lim_wr;
    logic             cfg_wr;
    logic             below;

    // two words per channel after the global word
    assign lim_hit[g] = (paddr == CH_BASE + 8'(g) * CH_STRIDE);
    assign cfg_hit[g] = (paddr == CH_BASE + 8'(g) * CH_STRIDE + CH_CFG_OFS);
    assign lim_wr     = wr_acc & lim_hit[g] & glb_ok;
    assign cfg_wr     = wr_acc & cfg_hit[g] & glb_ok;
    assign lim_rd[g]  = {thr_sh_r, top_sh_r};
    assign cfg_rd[g]  = {cnt_r[CNT_W-1:1], ld_r, 3'b000, en_r, 3'b000,
                         mode_r == SCP_MODE_UPDOWN, 3'b000, pol_r, 1'b0, psc_sh_r};

    // code 0..6 gives ratio 2..128, code 7 clamps to 128
    // clamping keeps the prescaler at seven bits
    assign psc_eff = (psc_r > PSC_MAX) ? PSC_MAX : psc_r;
    assign psc_lim = 7'((8'h02 << psc_eff) - 8'h01);
    assign step    = mtick & (psc_cnt_r == psc_lim);

    // software-facing settings
    // enable, polarity and mode act at once; limits wait for a boundary
    always_ff @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        top_sh_r <= TOP_RST;
        thr_sh_r <= THR_RST;
        psc_sh_r <= PSC_RST;
        pol_r    <= 1'b0;
        mode_r   <= SCP_MODE_UP;
        en_r     <= 1'b0;
        ld_r     <= 1'b0;
      end
      else
      begin
        if (lim_wr)
        begin
          top_sh_r <= pwdata[LIM_TOP_LSB +: CNT_W];
          thr_sh_r <= pwdata[LIM_THR_LSB +: CNT_W];
        end
        if (cfg_wr)
        begin
          psc_sh_r <= pwdata[CFG_PSC_LSB +: PSC_W];
          pol_r    <= pwdata[CFG_POL_BIT];
          mode_r   <= pwdata[CFG_MODE_BIT] ? SCP_MODE_UPDOWN : SCP_MODE_UP;
          en_r     <= pwdata[CFG_EN_BIT];
          ld_r     <= pwdata[CFG_LD_BIT];
        end
      end
    end

    // boundary is the step that returns the count to zero
    // a disabled channel is always at a boundary, so loads apply at once
    assign bnd = ~en_r | (step & (top_r == '0 | cnt_nxt == '0));

    // shadows move to active copies only at a boundary
    // load enable is sticky: while set, each boundary copies again
    always_ff @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        top_r <= TOP_RST;
        thr_r <= THR_RST;
        psc_r <= PSC_RST;
      end
      else if (bnd && ld_r)
      begin
        top_r <= top_sh_r;
        thr_r <= thr_sh_r;
        psc_r <= psc_sh_r;
      end
    end

    // next count and direction
    // a zero limit parks the counter at zero
    always_comb
    begin
      cnt_nxt = cnt_r;
      dir_nxt = dir_r[g];
      if (top_r == '0)
      begin
        cnt_nxt = '0;
        dir_nxt = 1'b0;
      end
      else if (mode_r == SCP_MODE_UP)
      begin
        // wrap to zero after the limit
        cnt_nxt = (cnt_r >= top_r) ? '0 : cnt_r + 16'h0001;
        dir_nxt = 1'b0;
      end
      else
      begin
        // turn around at the limit and at zero
        if (!dir_r[g] && cnt_r >= top_r)
        begin
          cnt_nxt = top_r - 16'h0001;
          dir_nxt = 1'b1;
        end
        else if (dir_r[g] && cnt_r == '0)
        begin
          cnt_nxt = 16'h0001;
          dir_nxt = 1'b0;
        end
        else
          cnt_nxt = dir_r[g] ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
      end
    end

    // prescaler and counter; a limit lowered below the count wraps at once
    // prescaler restarts at each step, so a new ratio starts clean
    always_ff @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        psc_cnt_r <= '0;
        cnt_r     <= '0;
        dir_r[g]  <= 1'b0;
      end
      else if (!en_r)
      begin
        psc_cnt_r <= '0;
        cnt_r     <= '0;
        dir_r[g]  <= 1'b0;
      end
      else if (mtick)
      begin
        psc_cnt_r <= step ? '0 : psc_cnt_r + 7'h01;
        if (step)
        begin
          cnt_r    <= cnt_nxt;
          dir_r[g] <= dir_nxt;
        end
      end
    end

    // threshold compare on the active copy
    assign below = (cnt_r < thr_r);

    // output level; one clock behind the counter
    // registered so a decode change never glitches a pin
    always_ff @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
        out_r[g] <= 1'b1;
      // inactive level is the above-threshold level
      else if (!en_r)
        out_r[g] <= ~pol_r;
      // polarity level below threshold, inverse at or above
      else
        out_r[g] <= below ? pol_r : ~pol_r;
    end
  end

endmodule

// ---- sim/scp_checker.sv ----
// checker for the pwm block's bus and pin relations
module scp_checker
  import scp_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [5:0]  pwm_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic [2:0] bus_r;
  wire        quiet = !psel && bus_r == 3'h0;
  // mapped: global word, channel words, status; the gap before status errs
  wire        bad_a = paddr[1:0] != 2'h0 ||
                      (paddr >= CH_BASE + 8'(NUM_CH) * CH_STRIDE && paddr != STAT_OFS);
  // recent bus activity; a write reaches the pins a cycle or two later
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      bus_r <= 3'h0;
    else
      bus_r <= {bus_r[1:0], psel};
  end
  sequence s_rd;
    psel && !penable && !pwrite;
  endsequence
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_unmapped: assert property (psel && !penable && bad_a |=> pslverr)
    else $error("unmapped address not flagged");
  chk_err_mapped: assert property (psel && !penable && !bad_a |=> !pslverr)
    else $error("mapped address flagged");
  chk_glb_bits: assert property (
    s_rd ##0 paddr == GLB_OFS |=> (prdata & ~GLB_MASK) == 32'h0)
    else $error("global word holds extra bits");
  chk_reset_out: assert property ($fell(sys_rst) |-> pwm_out == 6'h3f)
    else $error("outputs not idle after reset");
  chk_stat_read: assert property (
    s_rd ##0 paddr == STAT_OFS |=> prdata[5:0] == $past(pwm_out))
    else $error("status differs from pins");
  chk_rdata_stand: assert property (
    !($past(psel) && !$past(penable)) |-> $stable(prdata))
    else $error("read data moved outside setup");
  chk_out_hold: assert property (
    $changed(pwm_out[0]) && quiet |=> (!quiet || $stable(pwm_out[0]))[*8])
    else $error("output changed faster than a prescaled step");
endmodule
bind scp_pwm scp_checker scp_checker_i (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite,
  .pwdata, .prdata, .pready, .pslverr, .pwm_out);

// ---- sim/scp_load.sv ----
// load model: counts rising edges and high cycles per pin
module scp_load
  import scp_pkg::*;
(
  input wire logic       clk,
  input wire logic       clr,
  input wire logic [5:0] pwm_in,
  output int             rises [6],
  output int             highs [6]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] last_r;
  // passive: a load never drives the pin back
  always @(posedge clk)
  begin
    last_r <= pwm_in;
    for (int i = 0; i < NUM_CH; i++)
    begin
      rises[i] <= clr ? 0 : rises[i] + int'(pwm_in[i] && !last_r[i]);
      highs[i] <= clr ? 0 : highs[i] + int'(pwm_in[i]);
    end
  end
endmodule

// ---- sim/scp_pwm_tb.sv ----
// self-checking bench for the six-channel pwm block
module scp_pwm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scp_pkg::*;
  logic        clk = 1'b0, sys_rst = 1'b1, clr = 1'b0, err;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0]  pwm_out;
  int          bad_count = 0, n_checks = 0, rises [6], highs [6];
  // 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  scp_pwm scp_pwm_i (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .pwm_out);
  scp_load scp_load_i (.clk, .clr, .pwm_in(pwm_out), .rises, .highs);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi);
    check(32'(v >= lo && v <= hi), 32'h1);
  endtask
  // one transfer; released only after pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic meas(input int n);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic t_regs();
    check(pwm_out, 6'h3f); // idle after reset
    apb(1'b1, CH_BASE, 32'h0002_0003);
    apb(1'b0, CH_BASE, 32'h0);
    check(rd, 32'h0); // write before enable ignored
    apb(1'b1, GLB_OFS, 32'hffff_ffff);
    apb(1'b0, GLB_OFS, 32'h0);
    check(rd, GLB_MASK); // two bits kept
    apb(1'b0, 8'h48, 32'h0);
    check({rd[30:0], err}, 32'h1); // unmapped refused
    apb(1'b0, 8'h34, 32'h0);
    check({rd[30:0], err}, 32'h1); // gap before status refused
    for (int n = 0; n < NUM_CH; n++)
    begin
      apb(1'b1, CH_BASE + 8'(8 * n), 32'h0001_0002 + n);
      apb(1'b1, CH_BASE + 8'(8 * n) + CH_CFG_OFS, 32'h0000_0115);
      apb(1'b0, CH_BASE + 8'(8 * n), 32'h0);
      check(rd, 32'h0001_0002 + n); // own limit word
      apb(1'b0, CH_BASE + 8'(8 * n) + CH_CFG_OFS, 32'h0);
      check(rd, 32'h0000_0115); // config word
    end
    check(pwm_out, 6'h00); // disabled at inactive level
  endtask
  task automatic t_wave();
    apb(1'b1, 8'h04, 32'h0002_0003);
    apb(1'b1, 8'h0c, 32'h0002_0003);
    apb(1'b1, 8'h14, 32'h0001_0003);
    apb(1'b1, 8'h08, 32'h0001_1010);
    apb(1'b1, 8'h10, 32'h0001_1110);
    apb(1'b1, 8'h18, 32'h0001_1000);
    meas(1000);
    rng(rises[0], 19, 21); // eight ticks a period
    rng(highs[0], 470, 530); // half duty
    rng(rises[1], 12, 15); // twelve ticks a period
    rng(highs[1], 470, 530); // symmetric duty
    rng(rises[2], 19, 21); // independent channel
    rng(highs[2], 720, 780); // inverted polarity
    apb(1'b1, 8'h18, 32'h0000_1000);
    apb(1'b1, 8'h14, 32'h0003_0003);
    meas(1000);
    rng(highs[2], 720, 780); // kept without load
  endtask
  task automatic t_stop();
    apb(1'b1, 8'h08, 32'h0001_0010);
    repeat (3) @(posedge clk);
    check(pwm_out[0], 1'b0); // inactive level
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0001_0010); // counter held at zero
    apb(1'b0, STAT_OFS, 32'h0);
    check(rd[0], 1'b0); // status of stopped pin
  endtask
  // prescale sweep; code 7 saturates at the largest ratio
  task automatic t_psc();
    apb(1'b1, 8'h1c, 32'h0001_0001);
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, 8'h20, 32'h0001_1010 | c);
      repeat (1700) @(posedge clk);
      meas(3200);
      rng(rises[3], (128 >> (c > 6 ? 6 : c)) - 1, (128 >> (c > 6 ? 6 : c)) + 1);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_wave();
    t_stop();
    t_psc();
    conclude();
  end
  // watchdog; the sequence needs about 41k cycles
  initial
  begin
    repeat (90000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule
